/* design/lrs_consts.svh */
/*
  Constants of the refresh and self-refresh block: mode-register indices,
  field positions, reset values, command codes and timing figures.
  Assumes it is included by bare name into design and bench files.
*/
`ifndef LRS_CONSTS_SVH
`define LRS_CONSTS_SVH

// ----------------------------------------------------------------------
// Timing, in picoseconds and clocks
// ----------------------------------------------------------------------
`define LRS_CLK_PERIOD_PS    25000
`define LRS_PB_INTERVAL_PS   488000
`define LRS_RFC_PB_PS        190000
`define LRS_RFC_AB_PS        380000
`define LRS_ABORT_EXTRA_PS   17500
`define LRS_XSR_EXTRA_PS     7500
`define LRS_SR_MIN_PS        15000
`define LRS_SR_MIN_NCK       3
`define LRS_XSR_MIN_NCK      2

// ----------------------------------------------------------------------
// Array geometry and mode registers
// ----------------------------------------------------------------------
`define LRS_BANKS            8
`define LRS_SEGS             8
`define LRS_PB_PER_AB        4'h8
`define LRS_MR_RATE          6'h04
`define LRS_MR_BANK_MASK     6'h10
`define LRS_MR_SEG_MASK      6'h11
`define LRS_ABORT_BIT        3
`define LRS_MASK_RESET       8'h00

// ----------------------------------------------------------------------
// First-edge CA[4:0] command codes
// ----------------------------------------------------------------------
`define LRS_CA_SRE           5'h18
`define LRS_CA_SRX           5'h14
`define LRS_CA_REF           5'h08
`define LRS_CA_MRW1          5'h06
`define LRS_CA_MRW2          5'h16
`define LRS_CA_MRR1          5'h0E
`define LRS_CA_CAS2          5'h12
`define LRS_CA_MPC           5'h00

`endif

/* design/lrs_pkg.sv */
/*
  Types shared by the refresh and self-refresh block.
  Assumes nothing of its surroundings.
*/
package lrs_pkg;

  typedef enum logic [1:0] {
    LRS_ACTIVE,
    LRS_SELF_REF,
    LRS_SR_PD,
    LRS_EXIT_WAIT
  } lrs_state_type;

  typedef enum logic [2:0] {
    LRS_CMD_SRE,
    LRS_CMD_SRX,
    LRS_CMD_REF,
    LRS_CMD_MRW1,
    LRS_CMD_MRW2,
    LRS_CMD_LIMITED,
    LRS_CMD_OTHER
  } lrs_cmd_type;

endpackage : lrs_pkg

/* design/lrs_sr_engine.sv */
/*
  Internal self-refresh engine: a free timer walks bank and segment
  pointers and starts one internal refresh per interval unless masked.
  Assumes i_run, i_abort and the masks come from logic on i_clk.
*/
`timescale 1ns/100ps
`include "lrs_consts.svh"

module lrs_sr_engine #(
  parameter int unsigned INTERVAL_CYC = 19,
  parameter int unsigned BUSY_CYC     = 8,
  parameter int unsigned BANKS        = `LRS_BANKS,
  parameter int unsigned SEGS         = `LRS_SEGS
) (
  input  wire logic                     i_clk,
  input  wire logic                     i_rst,
  input  wire logic                     i_ce,
  input  wire logic                     i_run,
  input  wire logic                     i_abort,
  input  wire logic [BANKS-1:0]         i_bank_mask,
  input  wire logic [SEGS-1:0]          i_seg_mask,
  output logic                          o_start,
  output logic                          o_busy,
  output logic [$clog2(BANKS)-1:0]      o_bank,
  output logic [$clog2(SEGS)-1:0]       o_seg
);

  logic [15:0] tick_cnt;
  logic [7:0]  busy_cnt;
  logic        tick;
  logic        blocked;
  logic        advance;
  logic [BANKS-1:0] bank_hit;
  logic [SEGS-1:0]  seg_hit;

  // ----------------------------------------------------------------------
  // Mask lookup
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < BANKS; g = g + 1) begin : g_bank
      assign bank_hit[g] = i_bank_mask[g] && (o_bank == ($clog2(BANKS))'(g));
    end
    for (g = 0; g < SEGS; g = g + 1) begin : g_seg
      assign seg_hit[g] = i_seg_mask[g] && (o_seg == ($clog2(SEGS))'(g));
    end
  endgenerate

  assign tick    = i_run && (tick_cnt == 16'(INTERVAL_CYC - 1));
  // R16 bank mask blocks whole bank.
  // R17 segment mask blocks segments in unmasked banks.
  assign blocked = (|bank_hit) || (|seg_hit);
  // R18 abort leaves the counter unchanged.
  assign advance = (tick && !o_busy && blocked) ||
                   (o_busy && (busy_cnt == 8'h01) && !i_abort);

  // ----------------------------------------------------------------------
  // Interval timer
  // ----------------------------------------------------------------------
  // R11 internal timer keeps refreshing.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tick_cnt <= 16'h0000;
    end else if (i_ce) begin
      if (!i_run || tick) begin
        tick_cnt <= 16'h0000;
      end else begin
        tick_cnt <= tick_cnt + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------------
  // One refresh in flight
  // ----------------------------------------------------------------------
  // A refresh already running when the run request drops is allowed to
  // finish, unless i_abort is high, which drops it at the next edge.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_start  <= 1'b0;
      o_busy   <= 1'b0;
      busy_cnt <= 8'h00;
    end else if (i_ce) begin
      o_start <= 1'b0;
      if (o_busy) begin
        // R18 abandon refresh on abort.
        if (i_abort || busy_cnt == 8'h01) begin
          o_busy   <= 1'b0;
          busy_cnt <= 8'h00;
        end else begin
          busy_cnt <= busy_cnt - 8'h01;
        end
      end else if (tick && !blocked && !i_abort) begin
        o_start  <= 1'b1;
        o_busy   <= 1'b1;
        busy_cnt <= 8'(BUSY_CYC);
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_bank <= '0;
      o_seg  <= '0;
    end else if (i_ce && advance) begin
      if (o_bank == ($clog2(BANKS))'(BANKS - 1)) begin
        o_bank <= '0;
        o_seg  <= o_seg + 1'b1;
      end else begin
        o_bank <= o_bank + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  bank_mask_skip_a : assert property ( // R16
    @(posedge i_clk) disable iff (i_rst || !i_ce)
    (tick && !o_busy && (|bank_hit)) |=> (!o_start && !o_busy))
    else $error("Masked bank was refreshed.");

  seg_mask_skip_a : assert property ( // R17
    @(posedge i_clk) disable iff (i_rst || !i_ce)
    (tick && !o_busy && (|seg_hit)) |=> !o_start ##0 $changed(o_bank))
    else $error("Masked segment was refreshed or pointer stuck.");

  abort_hold_a : assert property ( // R18
    @(posedge i_clk) disable iff (i_rst || !i_ce)
    (i_abort && o_busy) |=> (!o_busy && $stable(o_bank) && $stable(o_seg)))
    else $error("Abort did not drop refresh or moved the counter.");

  timer_run_a : assert property ( // R11
    @(posedge i_clk) disable iff (i_rst || !i_ce)
    (o_start ##1 ((!i_abort) [*7])) |-> (o_busy && (busy_cnt == 8'h01)) ##1 !o_busy)
    else $error("Internal refresh length wrong.");

endmodule : lrs_sr_engine

/* design/lrs_refresh_ctrl.sv */
/*
  Refresh and self-refresh control of one DRAM channel: command decode,
  self-refresh and nested power-down states, exit timing, post-exit
  refresh debt and the partial-array mask registers.
  Assumes CS, CA and CKE arrive as pins on the device clock i_clk.
*/
`timescale 1ns/100ps
`include "lrs_consts.svh"

// Operation
// R1 - controller resets pulled-in count on slower rate
// R2 - controller refreshes at reported or faster rate
// R3 - read needs read-to-precharge plus precharge before per-bank refresh
// R4 - one extra refresh between exit and entry
// R5 - extra refresh outside regular interval accounting
// R6 - eight banks, 8192 refreshes per window
// R7 - abort exit wait is refresh cycle plus 17.5ns
// R8 - entry is two edges, coded CA
// R9 - entry only when idle, bursts done
// R10 - limited commands accepted during self-refresh
// R11 - device refreshes itself from internal timer
// R12 - controller honours minimum self-refresh residency
// R13 - limited commands until exit wait elapses
// R14 - power-down nests inside self-refresh
// R15 - bank mask register at index 16
// R16 - set bank bit blocks whole bank
// R17 - segment mask blocks segments in enabled banks
// R18 - abort enable drops refresh, keeps counter
// R19 - at most 16 refreshes per two intervals
// R20 - up to eight postponed, frozen during self-refresh
// R21 - controller keeps separate refresh counters
module lrs_refresh_ctrl
  import lrs_pkg::*;
#(
  parameter int unsigned PB_INTERVAL_CYC = `LRS_PB_INTERVAL_PS / `LRS_CLK_PERIOD_PS,
  parameter int unsigned RFC_PB_CYC      =
    (`LRS_RFC_PB_PS + `LRS_CLK_PERIOD_PS - 1) / `LRS_CLK_PERIOD_PS,
  parameter int unsigned ABORT_CYC       =
    (`LRS_RFC_PB_PS + `LRS_ABORT_EXTRA_PS + `LRS_CLK_PERIOD_PS - 1) / `LRS_CLK_PERIOD_PS,
  parameter int unsigned XSR_NS_CYC      =
    (`LRS_RFC_AB_PS + `LRS_XSR_EXTRA_PS + `LRS_CLK_PERIOD_PS - 1) / `LRS_CLK_PERIOD_PS,
  parameter int unsigned SR_NS_CYC       =
    (`LRS_SR_MIN_PS + `LRS_CLK_PERIOD_PS - 1) / `LRS_CLK_PERIOD_PS
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_ce,
  input  wire logic        i_cs,
  input  wire logic [5:0]  i_ca,
  input  wire logic        i_cke,
  output logic             o_self_refresh,
  output logic             o_power_down,
  output logic             o_cmd_ready,
  output logic             o_extra_owed,
  output logic             o_cmd_illegal,
  output logic [7:0]       o_bank_mask,
  output logic [7:0]       o_seg_mask,
  output logic             o_abort_en,
  output logic             o_int_ref_start,
  output logic             o_int_ref_busy,
  output logic [2:0]       o_int_ref_bank,
  output logic [2:0]       o_int_ref_seg
);

  localparam int unsigned XSR_CYC =
    (XSR_NS_CYC > `LRS_XSR_MIN_NCK) ? XSR_NS_CYC : `LRS_XSR_MIN_NCK;
  localparam int unsigned SR_MIN_CYC =
    (SR_NS_CYC > `LRS_SR_MIN_NCK) ? SR_NS_CYC : `LRS_SR_MIN_NCK;

  lrs_state_type state;
  lrs_state_type next_state;
  lrs_cmd_type   kind;
  logic       cs_m, cs_s, cke_m, cke_s;
  logic [5:0] ca_m, ca_s;
  logic       pend_valid;
  logic [5:0] pend_ca;
  logic       cmd_fire;
  logic       in_window;
  logic       allowed;
  logic       protect_hit;
  logic       mrw_armed;
  logic [5:0] mrw_addr;
  logic       mrw_op7;
  logic [7:0] mrw_op;
  logic       mrw_take;
  logic       srx_take;
  logic       next_illegal;
  logic [7:0] exit_cnt;
  logic [7:0] res_cnt;
  logic [3:0] pb_cnt;

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cs_m  <= 1'b0;
      cs_s  <= 1'b0;
      ca_m  <= 6'h00;
      ca_s  <= 6'h00;
      cke_m <= 1'b1;
      cke_s <= 1'b1;
    end else if (i_ce) begin
      cs_m  <= i_cs;
      cs_s  <= cs_m;
      ca_m  <= i_ca;
      ca_s  <= ca_m;
      cke_m <= i_cke;
      cke_s <= cke_m;
    end
  end

  // ----------------------------------------------------------------------
  // Two-edge command capture and decode
  // ----------------------------------------------------------------------
  // R8 first edge CS high, second low.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pend_valid <= 1'b0;
      pend_ca    <= 6'h00;
    end else if (i_ce) begin
      pend_valid <= cs_s && cke_s && !pend_valid;
      if (cs_s && !pend_valid) begin
        pend_ca <= ca_s;
      end
    end
  end

  assign cmd_fire = pend_valid && !cs_s && cke_s;

  always_comb begin
    case (pend_ca[4:0])
      `LRS_CA_SRE:  kind = LRS_CMD_SRE;
      `LRS_CA_SRX:  kind = LRS_CMD_SRX;
      `LRS_CA_REF:  kind = LRS_CMD_REF;
      `LRS_CA_MRW1: kind = LRS_CMD_MRW1;
      `LRS_CA_MRW2: kind = LRS_CMD_MRW2;
      `LRS_CA_MRR1,
      `LRS_CA_CAS2,
      `LRS_CA_MPC:  kind = LRS_CMD_LIMITED;
      default:      kind = LRS_CMD_OTHER;
    endcase
  end

  assign in_window   = (state != LRS_ACTIVE);
  assign protect_hit = (mrw_addr == `LRS_MR_BANK_MASK) ||
                       (mrw_addr == `LRS_MR_SEG_MASK) || (mrw_addr == `LRS_MR_RATE);
  // R10 limited set inside self-refresh.
  // R13 same set until exit wait ends.
  assign allowed     = (kind == LRS_CMD_MRW1) || (kind == LRS_CMD_LIMITED) ||
                       ((kind == LRS_CMD_MRW2) && !protect_hit) ||
                       ((kind == LRS_CMD_SRX) && (state == LRS_SELF_REF));
  assign mrw_op      = {mrw_op7, pend_ca[5], ca_s};
  assign mrw_take    = cmd_fire && (kind == LRS_CMD_MRW2) && mrw_armed &&
                       (!in_window || !protect_hit);
  assign srx_take    = cmd_fire && (kind == LRS_CMD_SRX) && (state == LRS_SELF_REF);

  // An entry with debt owed or an early exit still acts, since the device cannot refuse it;
  // commands outside the limited set inside the window are flagged and take no effect.
  always_comb begin
    next_illegal = 1'b0;
    if (cmd_fire) begin
      if (in_window && !allowed) begin
        next_illegal = 1'b1;
      end
      // R4 entry while extra refresh owed.
      if ((kind == LRS_CMD_SRE) && o_extra_owed) begin
        next_illegal = 1'b1;
      end
      // R12 exit before minimum residency.
      if (srx_take && (res_cnt < 8'(SR_MIN_CYC))) begin
        next_illegal = 1'b1;
      end
      if ((kind == LRS_CMD_SRX) && (state == LRS_ACTIVE)) begin
        next_illegal = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Self-refresh state
  // ----------------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      LRS_ACTIVE: begin
        if (cmd_fire && (kind == LRS_CMD_SRE)) begin
          next_state = LRS_SELF_REF;
        end
      end
      LRS_SELF_REF: begin
        // R14 power-down nests in self-refresh.
        if (!cke_s) begin
          next_state = LRS_SR_PD;
        end else if (srx_take) begin
          next_state = LRS_EXIT_WAIT;
        end
      end
      LRS_SR_PD: begin
        if (cke_s) begin
          next_state = LRS_SELF_REF;
        end
      end
      LRS_EXIT_WAIT: begin
        if (exit_cnt == 8'h01) begin
          next_state = LRS_ACTIVE;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state          <= LRS_ACTIVE;
      o_self_refresh <= 1'b0;
      o_power_down   <= 1'b0;
      o_cmd_ready    <= 1'b1;
      o_cmd_illegal  <= 1'b0;
    end else if (i_ce) begin
      state          <= next_state;
      o_self_refresh <= (next_state == LRS_SELF_REF) || (next_state == LRS_SR_PD);
      o_power_down   <= (next_state == LRS_SR_PD);
      o_cmd_ready    <= (next_state == LRS_ACTIVE);
      o_cmd_illegal  <= next_illegal;
    end
  end

  // R7 shorter wait when abort enabled.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      exit_cnt <= 8'h00;
      res_cnt  <= 8'h00;
    end else if (i_ce) begin
      if (srx_take) begin
        exit_cnt <= o_abort_en ? 8'(ABORT_CYC) : 8'(XSR_CYC);
      end else if (state == LRS_EXIT_WAIT) begin
        exit_cnt <= exit_cnt - 8'h01;
      end
      if (state == LRS_ACTIVE) begin
        res_cnt <= 8'h00;
      end else if (res_cnt != 8'hFF) begin
        res_cnt <= res_cnt + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Post-exit refresh debt
  // ----------------------------------------------------------------------
  // R5 debt kept apart from interval counts.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_extra_owed <= 1'b0;
      pb_cnt       <= 4'h0;
    end else if (i_ce) begin
      if (srx_take) begin
        o_extra_owed <= 1'b1;
        pb_cnt       <= 4'h0;
      end else if (cmd_fire && (kind == LRS_CMD_REF) && !in_window && o_extra_owed) begin
        // R4 one all-bank or eight per-bank.
        if (pend_ca[5] || (pb_cnt == `LRS_PB_PER_AB - 4'h1)) begin
          o_extra_owed <= 1'b0;
          pb_cnt       <= 4'h0;
        end else begin
          pb_cnt <= pb_cnt + 4'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Mode registers
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mrw_armed <= 1'b0;
      mrw_addr  <= 6'h00;
      mrw_op7   <= 1'b0;
    end else if (i_ce && cmd_fire) begin
      mrw_armed <= (kind == LRS_CMD_MRW1);
      if (kind == LRS_CMD_MRW1) begin
        mrw_addr <= ca_s;
        mrw_op7  <= pend_ca[5];
      end
    end
  end

  // R15 bank mask written by MRW.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_bank_mask <= `LRS_MASK_RESET;
      o_seg_mask  <= `LRS_MASK_RESET;
      o_abort_en  <= 1'b0;
    end else if (i_ce && mrw_take) begin
      if (mrw_addr == `LRS_MR_BANK_MASK) begin
        o_bank_mask <= mrw_op;
      end
      if (mrw_addr == `LRS_MR_SEG_MASK) begin
        o_seg_mask <= mrw_op;
      end
      if (mrw_addr == `LRS_MR_RATE) begin
        o_abort_en <= mrw_op[`LRS_ABORT_BIT];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Internal refresh engine
  // ----------------------------------------------------------------------
  lrs_sr_engine #(
    .INTERVAL_CYC (PB_INTERVAL_CYC),
    .BUSY_CYC     (RFC_PB_CYC),
    .BANKS        (`LRS_BANKS),
    .SEGS         (`LRS_SEGS)
  ) u_engine (
    .i_clk        (i_clk),
    .i_rst        (i_rst),
    .i_ce         (i_ce),
    .i_run        (o_self_refresh),
    .i_abort      (srx_take && o_abort_en),
    .i_bank_mask  (o_bank_mask),
    .i_seg_mask   (o_seg_mask),
    .o_start      (o_int_ref_start),
    .o_busy       (o_int_ref_busy),
    .o_bank       (o_int_ref_bank),
    .o_seg        (o_int_ref_seg)
  );

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  entry_decode_a : assert property ( // R8
    @(posedge i_clk) disable iff (i_rst || !i_ce)
    (cmd_fire && (kind == LRS_CMD_SRE) && (state == LRS_ACTIVE))
      |=> (o_self_refresh && !o_cmd_ready))
    else $error("Entry command did not enter self-refresh.");

  limited_set_a : assert property ( // R10
    @(posedge i_clk) disable iff (i_rst || !i_ce)
    (cmd_fire && in_window && (kind == LRS_CMD_OTHER)) |=> o_cmd_illegal)
    else $error("Disallowed command not flagged in self-refresh.");

  mask_protect_a : assert property ( // R13
    @(posedge i_clk) disable iff (i_rst || !i_ce)
    (cmd_fire && in_window && (kind == LRS_CMD_MRW2) && protect_hit)
      |=> ($stable(o_bank_mask) && $stable(o_seg_mask) && $stable(o_abort_en)))
    else $error("Protected register changed during self-refresh.");

  abort_exit_a : assert property ( // R7
    @(posedge i_clk) disable iff (i_rst || !i_ce)
    (srx_take && o_abort_en)
      |=> (!o_cmd_ready) [*8] ##1 !o_cmd_ready ##1 o_cmd_ready)
    else $error("Abort exit wait is not nine cycles.");

  normal_exit_a : assert property ( // R13
    @(posedge i_clk) disable iff (i_rst || !i_ce)
    (srx_take && !o_abort_en)
      |=> (!o_cmd_ready) [*8] ##1 (!o_cmd_ready) [*8] ##1 o_cmd_ready)
    else $error("Exit wait is not sixteen cycles.");

  extra_debt_a : assert property ( // R5
    @(posedge i_clk) disable iff (i_rst || !i_ce)
    srx_take |=> (o_extra_owed && (pb_cnt == 4'h0)))
    else $error("Exit did not raise the extra refresh debt.");

  pd_nest_a : assert property ( // R14
    @(posedge i_clk) disable iff (i_rst || !i_ce)
    ((state == LRS_SELF_REF) && !cke_s) |=> (o_power_down && o_self_refresh))
    else $error("Power-down not nested in self-refresh.");

  bank_write_a : assert property ( // R15
    @(posedge i_clk) disable iff (i_rst || !i_ce)
    (mrw_take && (mrw_addr == `LRS_MR_BANK_MASK)) |=> (o_bank_mask == $past(mrw_op)))
    else $error("Bank mask write lost.");

endmodule : lrs_refresh_ctrl

/* bench/lrs_mc_model.sv */
/*
  Controller-side model that drives the command pins of the block.
  Assumes one bench process calls its tasks, never two at once.
*/
`timescale 1ns/100ps
`include "lrs_consts.svh"

module lrs_mc_model (
  input  wire logic       i_clk,
  output logic            o_cs,
  output logic [5:0]      o_ca,
  output logic            o_cke
);
  initial begin
    o_cs  = 1'b0;
    o_ca  = 6'h00;
    o_cke = 1'b1;
  end

  // two-edge command
  // Released CA lines show the inverse payload so a stale level never passes.
  task automatic cmd(input logic [4:0] code, input logic b5, input logic [5:0] pl);
    @(posedge i_clk);
    o_cs <= 1'b1;
    o_ca <= {b5, code};
    @(posedge i_clk);
    o_cs <= 1'b0;
    o_ca <= pl;
    @(posedge i_clk);
    o_ca <= ~pl;
  endtask : cmd

  task automatic mrw(input logic [5:0] idx, input logic [7:0] op);
    cmd(`LRS_CA_MRW1, op[7], idx);
    cmd(`LRS_CA_MRW2, op[6], op[5:0]);
  endtask : mrw

  task automatic set_cke(input logic v);
    @(posedge i_clk);
    o_cke <= v;
  endtask : set_cke
endmodule : lrs_mc_model

/* bench/tb.sv */
/*
  Self-checking bench of the refresh and self-refresh control.
  Assumes the controller model drives the pins and i_ce stays high
  except for one short freeze while the device is active.
*/
`timescale 1ns/100ps
`include "lrs_consts.svh"

module tb;
  logic       i_clk = 1'b0;
  logic       i_rst = 1'b1;
  logic       ce    = 1'b1;
  logic       cs, cke, sr, pd, rdy, owed, ill, abt, st, busy;
  logic [5:0] ca;
  logic [7:0] bmask, smask;
  logic [2:0] bank, seg, b_at;
  int         err_count = 0;
  int         checks_done = 0;
  int         starts = 0;
  int         n;

  always #12.5 i_clk = ~i_clk;

  lrs_mc_model u_mc (.i_clk(i_clk), .o_cs(cs), .o_ca(ca), .o_cke(cke));

  lrs_refresh_ctrl u_lrs_refresh_ctrl (
    .i_clk(i_clk), .i_rst(i_rst), .i_ce(ce), .i_cs(cs), .i_ca(ca), .i_cke(cke),
    .o_self_refresh(sr), .o_power_down(pd), .o_cmd_ready(rdy), .o_extra_owed(owed),
    .o_cmd_illegal(ill), .o_bank_mask(bmask), .o_seg_mask(smask), .o_abort_en(abt),
    .o_int_ref_start(st), .o_int_ref_busy(busy), .o_int_ref_bank(bank), .o_int_ref_seg(seg)
  );

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up

  // A wait that runs out is a mismatch and ends the run.
  task automatic wait_on(ref logic s, input logic v, output int c);
    c = 0;
    while (s !== v && c < 40) begin
      @(negedge i_clk);
      c++;
    end
    if (s !== v) begin
      err_count++;
      $display("BAD wait exp %b got %b", v, s);
      wrap_up();
    end
  endtask : wait_on

  task automatic exit_chk(input logic [7:0] gap);
    u_mc.cmd(`LRS_CA_SRX, 1'b0, 6'h15);
    wait_on(sr, 1'b0, n);
    chk("owed", 8'h01, owed);
    wait_on(rdy, 1'b1, n);
    chk("exit_gap", gap, n[7:0]);
  endtask : exit_chk

  // Internal refreshes must never land on a masked bank or segment.
  always @(negedge i_clk) begin
    if (st === 1'b1) begin
      starts++;
      chk("ref_target", 8'h00, bmask[bank] | smask[seg]);
    end
  end

  // ----------------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    @(negedge i_clk);
    chk("ready", 8'h01, rdy);
    chk("masks", 8'h00, bmask | smask);
    $display("test reset done");
    u_mc.mrw(6'h10, 8'hA5);
    u_mc.mrw(6'h11, 8'h8E);
    repeat (6) @(negedge i_clk);
    chk("bank_mask", 8'hA5, bmask);
    chk("seg_mask", 8'h8E, smask);
    // A write sent while the clock enable is low must be lost.
    @(posedge i_clk);
    ce <= 1'b0;
    u_mc.mrw(6'h10, 8'h5A);
    @(posedge i_clk);
    ce <= 1'b1;
    repeat (6) @(negedge i_clk);
    chk("ce_freeze", 8'hA5, bmask);
    $display("test masks done");
    u_mc.cmd(`LRS_CA_SRE, 1'b1, 6'h2A);
    wait_on(sr, 1'b1, n);
    chk("sre_ready", 8'h00, rdy);
    // Long enough for the pointer to walk into a masked segment.
    repeat (180) @(negedge i_clk);
    chk("int_refresh", 8'h01, starts != 0);
    u_mc.cmd(`LRS_CA_REF, 1'b1, 6'h00);
    wait_on(ill, 1'b1, n);
    u_mc.cmd(5'h01, 1'b0, 6'h00);
    wait_on(ill, 1'b1, n);
    u_mc.mrw(6'h10, 8'h00);
    wait_on(ill, 1'b1, n);
    chk("mask_kept", 8'hA5, bmask);
    u_mc.set_cke(1'b0);
    wait_on(pd, 1'b1, n);
    u_mc.set_cke(1'b1);
    wait_on(pd, 1'b0, n);
    chk("sr_kept", 8'h01, sr);
    exit_chk(8'h10);
    $display("test self_refresh done");
    // Seven per-bank refreshes leave the debt; the eighth settles it.
    repeat (7) u_mc.cmd(`LRS_CA_REF, 1'b0, 6'h00);
    repeat (6) @(negedge i_clk);
    chk("owed_pb7", 8'h01, owed);
    u_mc.cmd(`LRS_CA_REF, 1'b0, 6'h00);
    repeat (6) @(negedge i_clk);
    chk("owed_pb8", 8'h00, owed);
    u_mc.mrw(6'h04, 8'h0B);
    u_mc.mrw(6'h10, 8'h00);
    u_mc.mrw(6'h11, 8'h00);
    repeat (6) @(negedge i_clk);
    chk("abort_en", 8'h01, abt);
    chk("masks_clear", 8'h00, bmask | smask);
    u_mc.cmd(`LRS_CA_SRE, 1'b0, 6'h15);
    wait_on(sr, 1'b1, n);
    // Exit lands inside a running internal refresh so the abort bites.
    wait_on(st, 1'b1, n);
    chk("busy", 8'h01, busy);
    b_at = bank;
    exit_chk(8'h09);
    chk("abort_bank", b_at, bank);
    u_mc.cmd(`LRS_CA_SRE, 1'b1, 6'h00);
    wait_on(ill, 1'b1, n);
    wait_on(sr, 1'b1, n);
    exit_chk(8'h09);
    u_mc.cmd(`LRS_CA_REF, 1'b1, 6'h00);
    repeat (6) @(negedge i_clk);
    chk("owed_clear", 8'h00, owed);
    $display("test abort done");
    wrap_up();
  end
endmodule : tb
